// ### sdc_pkg.sv
// Shared constants and carrier types for the synthesizer divider config
package sdc_pkg;

  // ****************************************************************
  // Frequency plan constants (all frequencies in kHz)
  // ****************************************************************
  localparam logic [19:0] SDC_REF_KHZ     = 20'd20000;
  localparam logic [19:0] SDC_VCO_MIN_KHZ = 20'd600000;
  localparam logic [19:0] SDC_VCO_MAX_KHZ = 20'd900000;
  localparam logic [19:0] SDC_2M_LO_KHZ   = 20'd144000;
  localparam logic [19:0] SDC_2M_HI_KHZ   = 20'd148000;

  // ****************************************************************
  // Multisynth encoding constants
  // ****************************************************************
  localparam logic [17:0] SDC_P1_OFFSET   = 18'd512;
  localparam int          SDC_FRAC_SHIFT  = 7;
  localparam logic [19:0] SDC_INT_P2      = 20'd0;
  localparam logic [19:0] SDC_INT_P3      = 20'd1;
  localparam logic [7:0]  SDC_RDIV_UNITY  = 8'd1;

  // ****************************************************************
  // Table sizes and reset values
  // ****************************************************************
  localparam int          SDC_EXT_DEPTH   = 16;
  localparam int          SDC_INT_DEPTH   = 4;
  localparam logic [2:0]  SDC_PATH_NONE   = 3'b000;
  localparam logic [19:0] SDC_END_MARK    = 20'd0;

  // One table entry: encoded patterns as produced by the table tool
  typedef struct packed {
    logic [19:0] carrier_khz;
    logic [19:0] vco_khz;
    logic [17:0] feedback_param_first;
    logic [19:0] feedback_param_second;
    logic [19:0] feedback_param_third;
    logic [17:0] stage2_param_first;
    logic [19:0] stage2_param_second;
    logic [19:0] stage2_param_third;
    logic [7:0]  final_divide;
  } sdc_entry_t;

  // Settings presented to the synthesizer
  typedef struct packed {
    logic [17:0] feedback_param_first;
    logic [19:0] feedback_param_second;
    logic [19:0] feedback_param_third;
    logic        pll_b_powerdown;
    logic [17:0] stage2_param_first;
    logic [19:0] stage2_param_second;
    logic [19:0] stage2_param_third;
    logic [7:0]  final_divider_zero;
    logic [7:0]  final_divider_one;
    logic [7:0]  final_divider_two;
    logic [2:0]  path_enable;
  } sdc_cfg_t;

endpackage : sdc_pkg

// ### sdc_table_rom.sv
// Internal program-memory frequency table with registered read data
`timescale 1ns/1ps
module sdc_table_rom #(
  parameter int DEPTH = sdc_pkg::SDC_INT_DEPTH,
  parameter int AW    = 2
) (
  // Clock and reset
  input  wire logic              clk_sys_i,
  input  wire logic              rst_i,
  // Read port
  input  wire logic [AW-1:0]     addr_i,
  output sdc_pkg::sdc_entry_t    data_o
);
  import sdc_pkg::*;

  sdc_entry_t rom_word;
  sdc_entry_t next_data;

  // Unused slots read as end markers so a scan stops there
  always_comb begin
    rom_word = '0;
    unique case (addr_i)
      AW'(0): rom_word = '{20'h23c58, 20'hd6a10, 18'h013fa, 20'h0005c,
                           20'h000fa, 18'h00100, 20'h00000, 20'h00001,
                           8'h01};
      AW'(1): rom_word = '{20'h23c85, 20'hd6b1e, 18'h013fc, 20'h000c0,
                           20'h007d0, 18'h00100, 20'h00000, 20'h00001,
                           8'h01};
      AW'(2): rom_word = '{20'h0c3b4, 20'hc3b40, 18'h0120a, 20'h00006,
                           20'h00019, 18'h00200, 20'h00000, 20'h00001,
                           8'h02};
      default: rom_word = '0;
    endcase
    next_data = (int'(addr_i) < DEPTH) ? rom_word : '0;
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      data_o <= '0;
    end else begin
      data_o <= next_data;
    end
  end

endmodule : sdc_table_rom

// ### sdc_entry_check.sv
// Plausibility check of one table entry against the frequency plan
`timescale 1ns/1ps
module sdc_entry_check (
  // Entry under test
  input  sdc_pkg::sdc_entry_t entry_i,
  // Verdict
  output logic                ok_o
);
  import sdc_pkg::*;

  logic [63:0] lhs;
  logic [63:0] rhs;
  logic [63:0] chain;
  logic [17:0] ms_int;
  logic        band_2m;
  logic        vco_ok;
  logic        fb_ok;
  logic        ms_ok;
  logic        rdiv_ok;

  always_comb begin
    // VCO must sit in its window
    vco_ok = (entry_i.vco_khz >= SDC_VCO_MIN_KHZ) &&
             (entry_i.vco_khz <= SDC_VCO_MAX_KHZ);
    // VCO over feedback divisor equals the 20 MHz reference, with
    // A+B/C = ((P1+512)+P2/P3)/128 undone from the encoded patterns
    lhs = 64'(entry_i.vco_khz) * 64'(entry_i.feedback_param_third);
    lhs = lhs << SDC_FRAC_SHIFT;
    rhs = (64'(entry_i.feedback_param_first) + 64'(SDC_P1_OFFSET)) *
          64'(entry_i.feedback_param_third);
    rhs = rhs + 64'(entry_i.feedback_param_second);
    rhs = rhs * 64'(SDC_REF_KHZ);
    fb_ok = (entry_i.feedback_param_third != '0) && (lhs == rhs);
    // Stage 2 is a pure integer divide down to the carrier chain
    ms_int = 18'((19'(entry_i.stage2_param_first) + 19'(SDC_P1_OFFSET))
                 >> SDC_FRAC_SHIFT);
    ms_ok = (entry_i.stage2_param_second == SDC_INT_P2) &&
            (entry_i.stage2_param_third == SDC_INT_P3) &&
            (entry_i.stage2_param_first[SDC_FRAC_SHIFT-1:0] == '0);
    chain = 64'(ms_int) * 64'(entry_i.carrier_khz) *
            64'(entry_i.final_divide);
    ms_ok = ms_ok && (chain == 64'(entry_i.vco_khz));
    band_2m = (entry_i.carrier_khz >= SDC_2M_LO_KHZ) &&
              (entry_i.carrier_khz <= SDC_2M_HI_KHZ);
    // Unity in 2M; elsewhere unity or an even ratio
    if (band_2m) begin
      rdiv_ok = (entry_i.final_divide == SDC_RDIV_UNITY);
    end else begin
      rdiv_ok = (entry_i.final_divide == SDC_RDIV_UNITY) ||
                ((entry_i.final_divide != '0) &&
                 !entry_i.final_divide[0]);
    end
    ok_o = vco_ok && fb_ok && ms_ok && rdiv_ok;
  end

endmodule : sdc_entry_check

// ### sdc_divider_config.sv
// Top level: table scan and synthesizer divider settings
//
// Functional notes
// - Derive dividers from a 20 MHz reference
// - VCO is carrier multiple, 600 to 900 MHz
// - VCO over feedback divisor equals reference
// - Second PLL always held powered down
// - First feedback pattern: 128A+floor(128B/C)-512
// - Second pattern 128B-C*floor; third equals C
// - All stage-2 dividers share one integer divisor
// - 2M band: stage-2 P2 zero, P3 one
// - Final dividers divide by one in 2M
// - Lower bands may use even final divide
// - Exactly one output path enabled after a hit; none at reset
// - Patterns come from table lookup, not computed
`timescale 1ns/1ps
module sdc_divider_config #(
  parameter int EXT_DEPTH = sdc_pkg::SDC_EXT_DEPTH,
  parameter int INT_DEPTH = sdc_pkg::SDC_INT_DEPTH
) (
  // Clock and reset
  input  wire logic                clk_sys_i,
  input  wire logic                rst_i,
  // Frequency request from controller software
  input  wire logic                req_i,
  input  wire logic [19:0]         target_khz_i,
  input  wire logic [1:0]          out_sel_i,
  output logic                     busy_o,
  output logic                     done_o,
  output logic                     miss_o,
  // External nonvolatile table memory
  output logic                     ext_rd_o,
  output logic [$clog2(EXT_DEPTH)-1:0] ext_addr_o,
  input  wire logic                ext_ack_i,
  input  sdc_pkg::sdc_entry_t      ext_entry_i,
  // Settings to the synthesizer
  output sdc_pkg::sdc_cfg_t        cfg_o,
  output logic                     cfg_valid_o
);
  import sdc_pkg::*;

  localparam int EAW = $clog2(EXT_DEPTH);
  localparam int IAW = (INT_DEPTH > 1) ? $clog2(INT_DEPTH) : 1;
  localparam logic [EAW-1:0] EXT_LAST = EAW'(EXT_DEPTH - 1);
  localparam logic [IAW-1:0] INT_LAST = IAW'(INT_DEPTH - 1);

  // Power-on settings: second PLL down, idle integer dividers at one
  localparam sdc_cfg_t CFG_RESET = '{
    feedback_param_first:  18'h0,
    feedback_param_second: 20'h0,
    feedback_param_third:  20'h0,
    pll_b_powerdown:       1'b1,
    stage2_param_first:    18'h0,
    stage2_param_second:   20'h0,
    stage2_param_third:    SDC_INT_P3,
    final_divider_zero:    SDC_RDIV_UNITY,
    final_divider_one:     SDC_RDIV_UNITY,
    final_divider_two:     SDC_RDIV_UNITY,
    path_enable:           SDC_PATH_NONE
  };

  // ****************************************************************
  // State encoding
  // ****************************************************************
  typedef enum logic [5:0] {
    ST_IDLE     = 6'b000001,
    ST_EXT_RD   = 6'b000010,
    ST_INT_RD   = 6'b000100,
    ST_INT_WAIT = 6'b001000,
    ST_CHECK    = 6'b010000,
    ST_APPLY    = 6'b100000
  } sdc_state_t;

  // One-hot path enable, unused paths powered down
  // Code 3 has no fourth path and folds onto path two
  function automatic logic [2:0] path_onehot(input logic [1:0] sel);
    logic [2:0] v;
    v = 3'b001;
    if (sel == 2'd1) begin
      v = 3'b010;
    end else if (sel[1]) begin
      v = 3'b100;
    end
    return v;
  endfunction : path_onehot

  // Final divide for a path: the entry ratio on the live path only
  function automatic logic [7:0] path_div(input logic [2:0] en,
                                          input int idx,
                                          input logic [7:0] div);
    return en[idx] ? div : SDC_RDIV_UNITY;
  endfunction : path_div

  // ****************************************************************
  // Registers
  // ****************************************************************
  sdc_state_t       state;
  sdc_state_t       next_state;
  logic [EAW-1:0]   ext_addr;
  logic [EAW-1:0]   next_ext_addr;
  logic [IAW-1:0]   int_addr;
  logic [IAW-1:0]   next_int_addr;
  logic             from_int;
  logic             next_from_int;
  // Target and path are latched so the inputs may move once taken
  logic [19:0]      target;
  logic [19:0]      next_target;
  logic [2:0]       path_sel;
  logic [2:0]       next_path_sel;
  sdc_entry_t       entry;
  sdc_entry_t       next_entry;
  sdc_cfg_t         cfg;
  sdc_cfg_t         next_cfg;
  logic             cfg_valid;
  logic             next_cfg_valid;
  logic             done;
  logic             next_done;
  logic             miss;
  logic             next_miss;

  sdc_entry_t       rom_data;
  logic             entry_ok;
  logic             hit;
  logic             end_mark;
  logic [2:0][7:0]  live_div;

  // ****************************************************************
  // Table sources and entry checker
  // ****************************************************************
  sdc_table_rom #(
    .DEPTH     (INT_DEPTH),
    .AW        (IAW)
  ) u_rom (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .addr_i    (int_addr),
    .data_o    (rom_data)
  );

  // Purely combinational: a verdict stands the cycle an entry lands
  sdc_entry_check u_check (
    .entry_i   (entry),
    .ok_o      (entry_ok)
  );

  // An entry only counts if the plan holds and the carrier matches;
  // a bad entry is skipped rather than pushed to the synthesizer
  assign hit      = entry_ok && (entry.carrier_khz == target);
  assign end_mark = (entry.carrier_khz == SDC_END_MARK);

  // Live path takes the entry ratio, idle paths stay at one
  for (genvar g = 0; g < 3; g++) begin : g_live_div
    assign live_div[g] = path_div(path_sel, g, entry.final_divide);
  end

  // ****************************************************************
  // Scan sequencer
  // ****************************************************************
  always_comb begin
    next_state     = state;
    next_ext_addr  = ext_addr;
    next_int_addr  = int_addr;
    next_from_int  = from_int;
    next_target    = target;
    next_path_sel  = path_sel;
    next_entry     = entry;
    next_done      = 1'b0;
    next_miss      = miss;
    unique case (state)
      // A request while busy is dropped without notice
      ST_IDLE: begin
        if (req_i) begin
          next_target   = target_khz_i;
          next_path_sel = path_onehot(out_sel_i);
          next_ext_addr = '0;
          next_int_addr = '0;
          next_from_int = 1'b0;
          next_miss     = 1'b0;
          next_state    = ST_EXT_RD;
        end
      end
      // Nonvolatile memory is searched first so a field-loaded
      // entry overrides the built-in one for the same carrier
      ST_EXT_RD: begin
        if (ext_ack_i) begin
          next_entry = ext_entry_i;
          next_state = ST_CHECK;
        end
      end
      ST_INT_RD: begin
        // Memory data is registered: wait one cycle for it
        next_state = ST_INT_WAIT;
      end
      ST_INT_WAIT: begin
        next_entry    = rom_data;
        next_from_int = 1'b1;
        next_state    = ST_CHECK;
      end
      // Bad entries are stepped over; an end mark or the last slot
      // hands the scan on to the built-in table
      ST_CHECK: begin
        if (hit) begin
          next_state = ST_APPLY;
        end else if (!from_int && !end_mark && ext_addr != EXT_LAST) begin
          next_ext_addr = ext_addr + EAW'(1);
          next_state    = ST_EXT_RD;
        end else if (!from_int) begin
          next_int_addr = '0;
          next_state    = ST_INT_RD;
        end else if (!end_mark && int_addr != INT_LAST) begin
          next_int_addr = int_addr + IAW'(1);
          next_state    = ST_INT_RD;
        end else begin
          // Table exhausted: old settings stay in force
          next_miss  = 1'b1;
          next_done  = 1'b1;
          next_state = ST_IDLE;
        end
      end
      ST_APPLY: begin
        // Settings register on this edge, together with done
        next_done  = 1'b1;
        next_state = ST_IDLE;
      end
      // A corrupted one-hot code falls back to idle instead of hanging
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state    <= ST_IDLE;
      ext_addr <= '0;
      int_addr <= '0;
      from_int <= 1'b0;
      target   <= '0;
      path_sel <= SDC_PATH_NONE;
      entry    <= '0;
      done     <= 1'b0;
      miss     <= 1'b0;
    end else begin
      state    <= next_state;
      ext_addr <= next_ext_addr;
      int_addr <= next_int_addr;
      from_int <= next_from_int;
      target   <= next_target;
      path_sel <= next_path_sel;
      entry    <= next_entry;
      done     <= next_done;
      miss     <= next_miss;
    end
  end

  // ****************************************************************
  // Synthesizer settings
  // ****************************************************************
  // Settings move only in the apply state, so the synthesizer never
  // sees a mix of two entries
  always_comb begin
    next_cfg       = cfg;
    next_cfg_valid = cfg_valid;
    // Second PLL is never used, whatever the table says
    next_cfg.pll_b_powerdown = 1'b1;
    if (state == ST_APPLY) begin
      next_cfg.feedback_param_first  = entry.feedback_param_first;
      next_cfg.feedback_param_second = entry.feedback_param_second;
      next_cfg.feedback_param_third  = entry.feedback_param_third;
      // One divisor drives all three stage-2 dividers
      next_cfg.stage2_param_first    = entry.stage2_param_first;
      next_cfg.stage2_param_second   = entry.stage2_param_second;
      next_cfg.stage2_param_third    = entry.stage2_param_third;
      next_cfg.path_enable           = path_sel;
      next_cfg.final_divider_zero    = live_div[0];
      next_cfg.final_divider_one     = live_div[1];
      next_cfg.final_divider_two     = live_div[2];
      next_cfg_valid = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      cfg                  <= CFG_RESET;
      cfg_valid            <= 1'b0;
    end else begin
      cfg                  <= next_cfg;
      cfg_valid            <= next_cfg_valid;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign busy_o      = (state != ST_IDLE);
  assign done_o      = done;
  assign miss_o      = miss;
  // Strobe and address stand until the table acknowledges
  assign ext_rd_o    = (state == ST_EXT_RD);
  assign ext_addr_o  = ext_addr;
  assign cfg_o       = cfg;
  assign cfg_valid_o = cfg_valid;

endmodule : sdc_divider_config

// ### sdc_divider_config_properties.sv
// Port-level checker for the synthesizer divider configuration block
`timescale 1ns/1ps
module sdc_divider_config_properties
  import sdc_pkg::*;
#(
  parameter int EXT_DEPTH = sdc_pkg::SDC_EXT_DEPTH
) (
  // Clock and reset
  input wire logic                         clk_sys_i,
  input wire logic                         rst_i,
  // Request side
  input wire logic                         req_i,
  input wire logic [19:0]                  target_khz_i,
  input wire logic [1:0]                   out_sel_i,
  input wire logic                         busy_o,
  input wire logic                         done_o,
  input wire logic                         miss_o,
  // Table memory side
  input wire logic                         ext_rd_o,
  input wire logic [$clog2(EXT_DEPTH)-1:0] ext_addr_o,
  input wire logic                         ext_ack_i,
  input sdc_pkg::sdc_entry_t               ext_entry_i,
  // Synthesizer side
  input sdc_pkg::sdc_cfg_t                 cfg_o,
  input wire logic                         cfg_valid_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  // Odd final divides other than one would skew the duty cycle
  function automatic logic div_ok(input logic [7:0] d);
    return d == 8'h01 || (d != 8'h00 && !d[0]);
  endfunction : div_ok

  property p_pllb; cfg_o.pll_b_powerdown; endproperty
  a_pllb: assert property (p_pllb)
    else $error("second PLL left powered up");
  property p_onehot; cfg_valid_o |-> $onehot(cfg_o.path_enable); endproperty
  a_onehot: assert property (p_onehot)
    else $error("output path enable not one-hot");
  property p_s2int;
    cfg_valid_o |-> cfg_o.stage2_param_second == 20'h0 &&
      cfg_o.stage2_param_third == 20'h1 && cfg_o.stage2_param_first[6:0] == 7'h0;
  endproperty
  a_s2int: assert property (p_s2int)
    else $error("stage two divisor not integer");
  property p_idle_div;
    (cfg_o.path_enable[0] || cfg_o.final_divider_zero == 8'h01) &&
    (cfg_o.path_enable[1] || cfg_o.final_divider_one == 8'h01) &&
    (cfg_o.path_enable[2] || cfg_o.final_divider_two == 8'h01);
  endproperty
  a_idle_div: assert property (p_idle_div)
    else $error("idle path final divider not one");
  property p_even;
    div_ok(cfg_o.final_divider_zero) && div_ok(cfg_o.final_divider_one) &&
    div_ok(cfg_o.final_divider_two);
  endproperty
  a_even: assert property (p_even)
    else $error("final divider neither one nor even");
  property p_hold; $changed(cfg_o) |-> done_o && !miss_o; endproperty
  a_hold: assert property (p_hold)
    else $error("settings changed outside a hit");
  property p_valid; $rose(cfg_valid_o) |-> done_o && !miss_o; endproperty
  a_valid: assert property (p_valid)
    else $error("settings marked valid without a hit");
  property p_extwait;
    ext_rd_o && !ext_ack_i |=> ext_rd_o && $stable(ext_addr_o);
  endproperty
  a_extwait: assert property (p_extwait)
    else $error("table read dropped before acknowledge");
  property p_extnext;
    ext_rd_o && ext_ack_i |=> !ext_rd_o ##1
      (!ext_rd_o || ext_addr_o == $past(ext_addr_o, 2) + 1'b1);
  endproperty
  a_extnext: assert property (p_extnext)
    else $error("table scan order broken");
  property p_start; req_i && !busy_o |=> busy_o && !miss_o; endproperty
  a_start: assert property (p_start)
    else $error("request not taken");
  property p_done; $rose(busy_o) |-> ##[3:600] done_o; endproperty
  a_done: assert property (p_done)
    else $error("lookup did not finish");
  property p_pulse; done_o |-> !busy_o ##1 !done_o; endproperty
  a_pulse: assert property (p_pulse)
    else $error("done not a single pulse");
endmodule : sdc_divider_config_properties

bind sdc_divider_config sdc_divider_config_properties #(
  .EXT_DEPTH(EXT_DEPTH)
) sdc_divider_config_properties_i (
  .clk_sys_i(clk_sys_i), .rst_i(rst_i), .req_i(req_i),
  .target_khz_i(target_khz_i), .out_sel_i(out_sel_i), .busy_o(busy_o),
  .done_o(done_o), .miss_o(miss_o), .ext_rd_o(ext_rd_o),
  .ext_addr_o(ext_addr_o), .ext_ack_i(ext_ack_i), .ext_entry_i(ext_entry_i),
  .cfg_o(cfg_o), .cfg_valid_o(cfg_valid_o)
);

// ### sdc_table_model.sv
// Behavioural model of the external nonvolatile frequency table
`timescale 1ns/1ps
module sdc_table_model
  import sdc_pkg::*;
(
  // Clock and reset
  input  wire logic                clk_sys_i,
  input  wire logic                rst_i,
  // Read port
  input  wire logic                rd_i,
  input  wire logic [3:0]          addr_i,
  input  wire logic [1:0]          dly_i,
  output logic                     ack_o,
  output sdc_pkg::sdc_entry_t      entry_o
);
  sdc_entry_t mem [16];
  logic [1:0] cnt;

  always_ff @(posedge clk_sys_i) begin
    cnt <= (rst_i || !rd_i) ? 2'h0 : cnt + 2'h1;
  end
  // Entries built offline by the table tool, never computed here
  assign ack_o   = rd_i && cnt == dly_i;
  // Outside an acknowledge the data lines show junk, not the last entry
  assign entry_o = ack_o ? mem[addr_i] : ~mem[addr_i];
endmodule : sdc_table_model

// ### sdc_divider_config_bench.sv
// Self-checking bench for the synthesizer divider configuration block
`timescale 1ns/1ps
module sdc_divider_config_bench;
  import sdc_pkg::*;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic       clk_sys_i = 1'b0;
  logic       rst_i     = 1'b1;
  logic       req_i     = 1'b0;
  logic [19:0] target_khz_i = 20'h0;
  logic [1:0] out_sel_i = 2'h0;
  logic [1:0] dly       = 2'h0;
  logic       busy_o, done_o, miss_o, ext_rd_o, ext_ack_i, cfg_valid_o;
  logic [3:0] ext_addr_o;
  sdc_entry_t ext_entry_i, e145, e50, e50b, bad;
  sdc_cfg_t   cfg_o, saved;
  int fails = 0;
  int cmp_count = 0;
  int cyc = 0;

  always #4 clk_sys_i = ~clk_sys_i;

  sdc_divider_config sdc_divider_config_i (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .req_i(req_i),
    .target_khz_i(target_khz_i), .out_sel_i(out_sel_i), .busy_o(busy_o),
    .done_o(done_o), .miss_o(miss_o), .ext_rd_o(ext_rd_o),
    .ext_addr_o(ext_addr_o), .ext_ack_i(ext_ack_i), .ext_entry_i(ext_entry_i),
    .cfg_o(cfg_o), .cfg_valid_o(cfg_valid_o));
  sdc_table_model sdc_table_model_i (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .rd_i(ext_rd_o),
    .addr_i(ext_addr_o), .dly_i(dly), .ack_o(ext_ack_i),
    .entry_o(ext_entry_i));

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic test_done;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done

  task automatic check(input logic [191:0] seen, exp, input string msg);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %0t %s seen %h want %h", $time, msg, seen, exp);
    end
  endtask : check

  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      test_done();
    end
  end

  function automatic sdc_entry_t mk(input logic [19:0] car, vco,
    input logic [17:0] p1, input logic [19:0] p2, p3,
    input logic [17:0] m1, input logic [19:0] m2, input logic [7:0] fd);
    return '{car, vco, p1, p2, p3, m1, m2, 20'h1, fd};
  endfunction : mk

  // One request pulse, optional refused pulse while busy, bounded wait
  task automatic lookup(input logic [19:0] t, input logic [1:0] s,
                        input bit poke);
    int n;
    @(posedge clk_sys_i); #1;
    req_i = 1'b1; target_khz_i = t; out_sel_i = s;
    @(posedge clk_sys_i); #1;
    req_i = 1'b0;
    if (poke) begin
      @(posedge clk_sys_i); #1;
      req_i = 1'b1; target_khz_i = 20'h1e240; out_sel_i = 2'h0;
      @(posedge clk_sys_i); #1;
      req_i = 1'b0;
    end
    n = 0;
    while (done_o !== 1'b1 && n < 600) begin
      @(posedge clk_sys_i); #1;
      n++;
    end
    check(n < 600, 1'b1, "lookup timeout");
  endtask : lookup

  // Settings after a hit; full compares the feedback patterns and stage-2 P1 to the entry
  task automatic chk_cfg(input sdc_entry_t e, input logic [1:0] s,
                         input bit full);
    logic [63:0] vco;
    logic [1:0] p;
    p = (s == 2'h3) ? 2'h2 : s;
    vco = ((64'(cfg_o.stage2_param_first) + 64'd512) >> 7) * e.carrier_khz
          * e.final_divide;
    check(miss_o, 1'b0, "miss");
    check(cfg_valid_o, 1'b1, "valid");
    check(cfg_o.pll_b_powerdown, 1'b1, "pll b");
    check(cfg_o.path_enable, 3'b001 << p, "path");
    check(cfg_o.final_divider_zero, p == 2'h0 ? e.final_divide : 8'h1,
          "div0");
    check(cfg_o.final_divider_one, p == 2'h1 ? e.final_divide : 8'h1,
          "div1");
    check(cfg_o.final_divider_two, p == 2'h2 ? e.final_divide : 8'h1,
          "div2");
    check({cfg_o.stage2_param_second, cfg_o.stage2_param_third,
           cfg_o.stage2_param_first[6:0]}, {20'h0, 20'h1, 7'h0},
          "stage2");
    check(vco >= 64'd600000 && vco <= 64'd900000, 1'b1, "vco");
    check(vco * cfg_o.feedback_param_third * 128, 64'd20000 *
          ((64'(cfg_o.feedback_param_first) + 512) * cfg_o.feedback_param_third
           + cfg_o.feedback_param_second), "feedback");
    if (full) begin
      check({cfg_o.feedback_param_first, cfg_o.feedback_param_second,
             cfg_o.feedback_param_third}, {e.feedback_param_first,
             e.feedback_param_second, e.feedback_param_third},
            "fb copy");
      check(cfg_o.stage2_param_first, e.stage2_param_first, "ms p1");
    end
  endtask : chk_cfg

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    e145 = mk(20'd145000, 20'd870000, 18'd5056, 20'h0, 20'h2, 18'd256,
              20'h0, 8'h1);
    bad  = mk(20'd145000, 20'd870000, 18'd5056, 20'h0, 20'h2, 18'd256,
              20'h1, 8'h1);
    e50b = mk(20'd50000, 20'd900000, 18'd5248, 20'h0, 20'h1, 18'd256,
              20'h0, 8'h3);
    e50  = mk(20'd50000, 20'd800000, 18'd4608, 20'h0, 20'h1, 18'd512,
              20'h0, 8'h2);
    for (int i = 0; i < 16; i++) sdc_table_model_i.mem[i] = '0;
    sdc_table_model_i.mem[0] = bad;
    sdc_table_model_i.mem[1] = e145;
    sdc_table_model_i.mem[2] = e50b;
    sdc_table_model_i.mem[3] = e50;
    repeat (6) @(posedge clk_sys_i);
    #1 rst_i = 1'b0;
    check({busy_o, done_o, miss_o, ext_rd_o, cfg_valid_o}, 5'h0, "rst");
    check(cfg_o, {18'h0, 20'h0, 20'h0, 1'b1, 18'h0, 20'h0, 20'h1, 8'h1,
                  8'h1, 8'h1, 3'b000}, "rst cfg");
    // Malformed stage-two entry skipped, next one taken
    lookup(20'd145000, 2'h1, 1'b0);
    chk_cfg(e145, 2'h1, 1'b1);
    // Slow memory, odd HF divide skipped, refused request while busy
    dly = 2'h3;
    lookup(20'd50000, 2'h3, 1'b1);
    chk_cfg(e50, 2'h3, 1'b1);
    // Not in external table: internal entries reached after end mark
    dly = 2'h1;
    lookup(20'd146520, 2'h0, 1'b0);
    chk_cfg(mk(20'd146520, 20'h0, 18'h0, 20'h0, 20'h1, 18'h0, 20'h0, 8'h1),
            2'h0, 1'b0);
    lookup(20'd50100, 2'h2, 1'b0);
    chk_cfg(mk(20'd50100, 20'h0, 18'h0, 20'h0, 20'h1, 18'h0, 20'h0, 8'h2),
            2'h2, 1'b0);
    // Unknown carrier: miss, settings left alone
    saved = cfg_o;
    lookup(20'd123456, 2'h1, 1'b0);
    check(miss_o, 1'b1, "miss flag");
    check(cfg_o, saved, "cfg kept");
    // Next request clears the miss flag and reaches a later built-in slot
    lookup(20'd146565, 2'h1, 1'b0);
    chk_cfg(mk(20'd146565, 20'h0, 18'h0, 20'h0, 20'h1, 18'h0, 20'h0, 8'h1),
            2'h1, 1'b0);
    test_done();
  end
endmodule : sdc_divider_config_bench
